/* File: design/emw_pkg.sv */
/*
 * Constants for the external memory wait, strobe and DRAM refresh block:
 * register indices, field positions, write masks, reset values, cycle
 * bases and the controller state encoding.
 * Assumes a byte-wide register port with a 4-bit register index.
 */
package emw_pkg;

   // Register indices on the byte-wide register port
   localparam logic [3:0] EMW_A_SWAIT = 4'h3;  // static_wait_count
   localparam logic [3:0] EMW_A_BSCH = 4'h4;   // static_byte_scheme
   localparam logic [3:0] EMW_A_DCTL2 = 4'h5;  // dram_bank_control, bank 2
   localparam logic [3:0] EMW_A_DCTL3 = 4'h6;  // dram_bank_control, bank 3
   localparam logic [3:0] EMW_A_DTIM2 = 4'h7;  // dram_bank_timing, bank 2
   localparam logic [3:0] EMW_A_DTIM3 = 4'h8;  // dram_bank_timing, bank 3
   localparam logic [3:0] EMW_A_DCW2 = 4'h9;   // dram_column_wait, bank 2
   localparam logic [3:0] EMW_A_DCW3 = 4'ha;   // dram_column_wait, bank 3
   localparam logic [3:0] EMW_A_RCNT = 4'hb;   // refresh_down_counter
   localparam logic [3:0] EMW_A_RINT = 4'hc;   // refresh_interval_reload
   localparam logic [3:0] EMW_A_XTIM = 4'hd;   // self_refresh_exit_timing
   localparam logic [3:0] EMW_A_RCTL = 4'he;   // refresh_control

   // Reset values
   localparam logic [7:0] EMW_RST_SWAIT = 8'h77;
   localparam logic [7:0] EMW_RST_BSCH = 8'h00;
   localparam logic [7:0] EMW_RST_DCTL = 8'h00;
   localparam logic [7:0] EMW_RST_DTIM = 8'h05;
   localparam logic [7:0] EMW_RST_DCW = 8'h03;
   localparam logic [7:0] EMW_RST_RCNT = 8'hff;
   localparam logic [7:0] EMW_RST_RINT = 8'hff;
   localparam logic [7:0] EMW_RST_XTIM = 8'h37;
   localparam logic [7:0] EMW_RST_RCTL = 8'h00;

   // Writable bits; reserved bits store nothing and read zero
   localparam logic [7:0] EMW_M_SWAIT = 8'h77;
   localparam logic [7:0] EMW_M_BSCH = 8'h03;
   localparam logic [7:0] EMW_M_DCTL = 8'h33;
   localparam logic [7:0] EMW_M_DTIM = 8'h05;
   localparam logic [7:0] EMW_M_DCW = 8'h03;
   localparam logic [7:0] EMW_M_XTIM = 8'h37;
   localparam logic [7:0] EMW_M_RCTL = 8'h7b;

   // Field positions
   localparam int EMW_F_SW1 = 4;       // bank 1 wait field [6:4]
   localparam int EMW_F_SHIFT = 0;     // row shift field [1:0]
   localparam int EMW_F_DSCH = 4;      // dram strobe scheme bit
   localparam int EMW_F_PAGE = 5;      // page mode bit
   localparam int EMW_F_PRE = 0;       // precharge select bit
   localparam int EMW_F_R2C = 2;       // row-to-column delay bit
   localparam int EMW_F_XPRE = 0;      // exit precharge field [2:0]
   localparam int EMW_F_XHOLD = 4;     // exit column hold field [5:4]
   localparam int EMW_F_SELF = 3;      // self refresh bit
   localparam int EMW_F_TAP = 4;       // refresh clock select [6:4]

   // Cycle bases
   localparam logic [4:0] EMW_SHIFT_BASE = 5'd8;
   localparam logic [3:0] EMW_REF_ROW_CYC = 4'd2; // row low in refresh

   // Controller states, one-hot
   typedef enum logic [10:0] {
      EMW_IDLE = 11'b000_0000_0001,
      EMW_ST_ACC = 11'b000_0000_0010,
      EMW_DR_ROW = 11'b000_0000_0100,
      EMW_DR_COL = 11'b000_0000_1000,
      EMW_DR_PRE = 11'b000_0001_0000,
      EMW_RF_COL = 11'b000_0010_0000,
      EMW_RF_ROW = 11'b000_0100_0000,
      EMW_RF_PRE = 11'b000_1000_0000,
      EMW_SR_COL = 11'b001_0000_0000,
      EMW_SR_HOLD = 11'b010_0000_0000,
      EMW_SR_EXIT = 11'b100_0000_0000
   } emw_state_e;

endpackage : emw_pkg

/* File: design/emw_ctrl.sv */
/*
 * External memory controller core: static bank wait states and byte
 * strobe scheme, DRAM bank row/column sequencing, timer refresh and
 * self-refresh, with its byte-wide register file.
 * Assumes requesters, register port and time-base taps run on ref_clk.
 */
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps

// Behaviour
// - Static bank inserts its programmed wait cycles
// - Static wait register resets to 0x77
// - Static byte scheme bit selects pin roles
// - Row address shifted by 8 to 11
// - DRAM strobe scheme bit selects pin roles
// - Page bit selects page or random mode
// - Precharge lasts one or two cycles
// - Row-to-column delay one or two cycles
// - Column strobe stretched by 0-3, reset 3
// - Enabling refresh loads counter, starts counting
// - Zero count runs refresh, then reloads
// - Clock select picks time-base tap
// - Enable bits choose refreshed DRAM banks
// - Self refresh: column then row strobe
// - DRAM access in self refresh exits it
// - Writing zero also exits self refresh
// - Exit: row up, hold, column up, precharge
// - Exit column hold 1 to 4 cycles
// - Exit precharge 2 to 9, reset 0x37
module emw_ctrl
   import emw_pkg::*;
(
   // Clock, reset, freeze
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic ce,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Access request, held until done
   input wire logic acc_req,
   input wire logic [1:0] acc_bank,
   input wire logic acc_write,
   input wire logic acc_hi,
   input wire logic acc_lo,
   input wire logic [23:0] acc_addr,
   output logic acc_done,
   // Time-base taps, divide by 2 up to 256
   input wire logic [7:0] time_base_tap,
   // Static bank pins
   output logic [1:0] sram_cs_n,
   output logic sram_rd_n,
   output logic sram_we_or_wl_n,
   output logic sram_hb_or_wh_n,
   output logic sram_lb_or_a0,
   // DRAM pins
   output logic [1:0] row_strobe_n,
   output logic dram_wl_or_we_n,
   output logic dram_wh_or_colh_n,
   output logic dram_col_or_coll_n,
   output logic [23:0] mux_addr,
   output logic self_refresh_active
);
   import emw_pkg::*;

   // Row address for a given shift field
   function automatic logic [23:0] emw_row(input logic [23:0] a,
                                           input logic [1:0] sh);
      emw_row = a >> (EMW_SHIFT_BASE + {3'h0, sh});
   endfunction : emw_row

   // Masked register write value
   function automatic logic [7:0] emw_wm(input logic [7:0] d,
                                         input logic [7:0] m);
      emw_wm = d & m;
   endfunction : emw_wm

   // Configuration registers
   logic [7:0] swait_r;      // static_wait_count
   logic [1:0] bsch_r;       // static_byte_scheme
   logic [7:0] dctl_r [2];   // dram_bank_control, banks 2 and 3
   logic [7:0] dtim_r [2];   // dram_bank_timing
   logic [7:0] dcw_r [2];    // dram_column_wait
   logic [7:0] rcnt_r;       // refresh_down_counter
   logic [7:0] rint_r;       // refresh_interval_reload
   logic [7:0] xtim_r;       // self_refresh_exit_timing
   logic [1:0] arf_en_r;     // auto_refresh_enable
   logic self_r;             // self_refresh_bit
   logic [2:0] tap_sel_r;    // refresh_clock_select
   logic tap_prev_r;         // Previous selected tap level
   logic ref_pend_r;         // Refresh due, not yet served

   // Sequencer state
   emw_state_e state_r, state_nxt;
   logic [3:0] cnt_r, cnt_nxt;       // Cycles left in the state
   logic row_open_r, row_open_nxt;   // Page mode row held open
   logic open_bank_r, open_bank_nxt; // Bank of the open row
   logic [23:0] open_row_r;          // Row of the last taken access, static ones included
   logic cur_bank_r;                 // Bank index within its pair
   logic cur_dram_r;                 // Access targets a DRAM bank
   logic cur_wr_r, cur_hi_r, cur_lo_r;
   logic [23:0] cur_addr_r;
   logic take_c, done_c, ref_done_c, self_clr_c;

   // Pin and answer registers
   logic [7:0] rdata_r;
   logic done_r;
   logic [1:0] cs_n_r, row_n_r;
   logic rd_n_r, spa_r, spb_r, spc_r, dpa_r, dpb_r, dpc_r, sra_r;
   logic [23:0] maddr_r;

   // Register port decode
   wire wr_rctl = reg_wr && reg_addr == EMW_A_RCTL;
   wire wr_rcnt = reg_wr && reg_addr == EMW_A_RCNT;
   wire [1:0] arf_wdata = reg_wdata[1:0];

   // Request qualified; a request is not retaken while done shows
   wire req_v = acc_req && !done_r;
   wire dreq = req_v && acc_bank[1];
   wire sreq = req_v && !acc_bank[1];
   wire db = acc_bank[0];
   wire [1:0] d_shift = dctl_r[db][EMW_F_SHIFT +: 2];
   wire row_hit = row_open_r && open_bank_r == db &&
                  open_row_r == emw_row(acc_addr, d_shift);

   // Per-access timing fields: DRAM bank timing, static bank wait and self refresh exit
   wire cb = cur_bank_r;
   wire [3:0] pre_cyc = {3'h0, dtim_r[cb][EMW_F_PRE]};
   wire [3:0] r2c_cyc = {3'h0, dtim_r[db][EMW_F_R2C]};
   wire [3:0] col_cyc_new = {2'h0, dcw_r[db][1:0]};
   wire [3:0] sw_cyc = sreq && acc_bank[0] ?
                       {1'b0, swait_r[EMW_F_SW1 +: 3]} :
                       {1'b0, swait_r[2:0]};
   wire [3:0] xhold_cyc = {2'h0, xtim_r[EMW_F_XHOLD +: 2]};
   wire [3:0] xpre_cyc = {1'b0, xtim_r[EMW_F_XPRE +: 3]} + 4'h1;

   // Refresh timer tick from the chosen tap
   wire tap_lvl = time_base_tap[tap_sel_r];
   wire tick = tap_lvl && !tap_prev_r;
   wire arf_on = arf_en_r != 2'b00;

   // Next state of the sequencer
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      row_open_nxt = row_open_r;
      open_bank_nxt = open_bank_r;
      take_c = 1'b0;
      done_c = 1'b0;
      ref_done_c = 1'b0;
      self_clr_c = 1'b0;
      case (state_r)
         EMW_IDLE: begin
            if (ref_pend_r && arf_on) begin
               state_nxt = row_open_r ? EMW_DR_PRE : EMW_RF_COL;
               cnt_nxt = row_open_r ? pre_cyc : 4'h0;
            end else if (self_r) begin
               state_nxt = row_open_r ? EMW_DR_PRE : EMW_SR_COL;
               cnt_nxt = row_open_r ? pre_cyc : 4'h0;
            end else if (sreq) begin
               take_c = 1'b1;
               state_nxt = EMW_ST_ACC;
               cnt_nxt = sw_cyc;
            end else if (dreq && row_hit) begin
               // page hit skips the row phase
               take_c = 1'b1;
               state_nxt = EMW_DR_COL;
               cnt_nxt = col_cyc_new;
            end else if (dreq && row_open_r) begin
               // Page miss closes the row first
               state_nxt = EMW_DR_PRE;
               cnt_nxt = pre_cyc;
            end else if (dreq) begin
               take_c = 1'b1;
               state_nxt = EMW_DR_ROW;
               cnt_nxt = r2c_cyc;
            end
         end
         EMW_ST_ACC: begin
            if (cnt_r == 4'h0) begin
               done_c = 1'b1;
               state_nxt = EMW_IDLE;
            end
         end
         EMW_DR_ROW: begin
            if (cnt_r == 4'h0) begin
               state_nxt = EMW_DR_COL;
               cnt_nxt = {2'h0, dcw_r[cb][1:0]};
            end
         end
         EMW_DR_COL: begin
            if (cnt_r == 4'h0) begin
               done_c = 1'b1;
               // page mode keeps the row open
               if (dctl_r[cb][EMW_F_PAGE]) begin
                  state_nxt = EMW_IDLE;
                  row_open_nxt = 1'b1;
                  open_bank_nxt = cb;
               end else begin
                  state_nxt = EMW_DR_PRE;
                  cnt_nxt = pre_cyc;
               end
            end
         end
         EMW_DR_PRE: begin
            row_open_nxt = 1'b0;
            if (cnt_r == 4'h0) begin
               state_nxt = EMW_IDLE;
            end
         end
         EMW_RF_COL: begin
            state_nxt = EMW_RF_ROW;
            cnt_nxt = EMW_REF_ROW_CYC - 4'h1;
         end
         EMW_RF_ROW: begin
            if (cnt_r == 4'h0) begin
               state_nxt = EMW_RF_PRE;
               cnt_nxt = {3'h0, dtim_r[0][EMW_F_PRE]};
            end
         end
         EMW_RF_PRE: begin
            if (cnt_r == 4'h0) begin
               ref_done_c = 1'b1;
               state_nxt = EMW_IDLE;
            end
         end
         EMW_SR_COL: begin
            state_nxt = EMW_SR_HOLD;
         end
         EMW_SR_HOLD: begin
            if (!self_r || dreq) begin
               self_clr_c = dreq;
               state_nxt = EMW_SR_EXIT;
               cnt_nxt = xhold_cyc;
            end
         end
         EMW_SR_EXIT: begin
            if (cnt_r == 4'h0) begin
               state_nxt = EMW_DR_PRE;
               cnt_nxt = xpre_cyc;
            end
         end
         default: begin
            state_nxt = EMW_IDLE;
         end
      endcase
      if (state_r != EMW_IDLE && cnt_r != 4'h0 &&
          state_nxt == state_r) begin
         cnt_nxt = cnt_r - 4'h1;
      end
   end

   // Pin strobes decoded from the present state
   wire st = state_r == EMW_ST_ACC;
   wire col_acc = state_r == EMW_DR_COL;
   // column stays low through the whole exit hold
   wire col_all = state_r == EMW_RF_COL || state_r == EMW_RF_ROW ||
                  state_r == EMW_SR_COL || state_r == EMW_SR_HOLD ||
                  state_r == EMW_SR_EXIT;
   wire col_act = col_acc || col_all;
   wire lane_hi = col_acc ? cur_hi_r : 1'b1;
   wire lane_lo = col_acc ? cur_lo_r : 1'b1;
   wire dwr = col_acc && cur_wr_r;
   wire dsch = dctl_r[col_acc ? cb : 1'b0][EMW_F_DSCH];
   wire swr = st && cur_wr_r;
   wire ssch = bsch_r[cb];
   wire [1:0] bank_one = cb ? 2'b10 : 2'b01;
   // An open page keeps its row low across static accesses
   wire [1:0] row_act =
      (state_r == EMW_DR_ROW || col_acc) ? bank_one :
      ((state_r == EMW_IDLE || st) && row_open_r) ?
         (open_bank_r ? 2'b10 : 2'b01) :
      (state_r == EMW_RF_ROW) ? arf_en_r :
      (state_r == EMW_SR_HOLD) ? 2'b11 : 2'b00;

   // Register read selection
   wire [7:0] rd_sel =
      reg_addr == EMW_A_SWAIT ? swait_r :
      reg_addr == EMW_A_BSCH ? {6'h00, bsch_r} :
      reg_addr == EMW_A_DCTL2 ? dctl_r[0] :
      reg_addr == EMW_A_DCTL3 ? dctl_r[1] :
      reg_addr == EMW_A_DTIM2 ? dtim_r[0] :
      reg_addr == EMW_A_DTIM3 ? dtim_r[1] :
      reg_addr == EMW_A_DCW2 ? dcw_r[0] :
      reg_addr == EMW_A_DCW3 ? dcw_r[1] :
      reg_addr == EMW_A_RCNT ? rcnt_r :
      reg_addr == EMW_A_RINT ? rint_r :
      reg_addr == EMW_A_XTIM ? xtim_r :
      reg_addr == EMW_A_RCTL ?
         {1'b0, tap_sel_r, self_r, 1'b0, arf_en_r} : 8'h00;

   // Configuration registers; reserved bits never stored
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         swait_r <= EMW_RST_SWAIT;
         bsch_r <= EMW_RST_BSCH[1:0];
         dctl_r <= '{EMW_RST_DCTL, EMW_RST_DCTL};
         dtim_r <= '{EMW_RST_DTIM, EMW_RST_DTIM};
         dcw_r <= '{EMW_RST_DCW, EMW_RST_DCW};
         rint_r <= EMW_RST_RINT;
         xtim_r <= EMW_RST_XTIM;
         tap_sel_r <= EMW_RST_RCTL[EMW_F_TAP +: 3];
      end else if (ce && reg_wr) begin
         case (reg_addr)
            EMW_A_SWAIT: swait_r <= emw_wm(reg_wdata, EMW_M_SWAIT);
            EMW_A_BSCH: bsch_r <= reg_wdata[1:0];
            EMW_A_DCTL2: dctl_r[0] <= emw_wm(reg_wdata, EMW_M_DCTL);
            EMW_A_DCTL3: dctl_r[1] <= emw_wm(reg_wdata, EMW_M_DCTL);
            EMW_A_DTIM2: dtim_r[0] <= emw_wm(reg_wdata, EMW_M_DTIM);
            EMW_A_DTIM3: dtim_r[1] <= emw_wm(reg_wdata, EMW_M_DTIM);
            EMW_A_DCW2: dcw_r[0] <= emw_wm(reg_wdata, EMW_M_DCW);
            EMW_A_DCW3: dcw_r[1] <= emw_wm(reg_wdata, EMW_M_DCW);
            EMW_A_RINT: rint_r <= reg_wdata;
            EMW_A_XTIM: xtim_r <= emw_wm(reg_wdata, EMW_M_XTIM);
            EMW_A_RCTL: tap_sel_r <= reg_wdata[EMW_F_TAP +: 3];
            default: begin
            end
         endcase
      end
   end

   // Refresh enable and self refresh bit; a set beats the hw clear
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         arf_en_r <= EMW_RST_RCTL[1:0];
         self_r <= 1'b0;
      end else if (ce) begin
         if (wr_rctl) begin
            arf_en_r <= arf_wdata;
         end
         if (wr_rctl) begin
            self_r <= reg_wdata[EMW_F_SELF];
         end else if (self_clr_c) begin
            self_r <= 1'b0;
         end
      end
   end

   // Refresh timer; counting pauses while a refresh is due
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         rcnt_r <= EMW_RST_RCNT;
         tap_prev_r <= 1'b0;
         ref_pend_r <= 1'b0;
      end else if (ce) begin
         tap_prev_r <= tap_lvl;
         if (wr_rctl && !arf_on && arf_wdata != 2'b00) begin
            rcnt_r <= rint_r;
         end else if (wr_rcnt) begin
            rcnt_r <= reg_wdata;
         end else if (ref_done_c) begin
            rcnt_r <= rint_r;
         end else if (arf_on && !ref_pend_r && tick && rcnt_r != 8'h00) begin
            rcnt_r <= rcnt_r - 8'h01;
         end
         if (ref_done_c) begin
            ref_pend_r <= 1'b0;
         end else if (arf_on && rcnt_r == 8'h00 && !wr_rctl) begin
            ref_pend_r <= 1'b1;
         end
      end
   end

   // Sequencer registers and latched request
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         state_r <= EMW_IDLE;
         cnt_r <= 4'h0;
         row_open_r <= 1'b0;
         open_bank_r <= 1'b0;
         open_row_r <= 24'h000000;
         {cur_bank_r, cur_dram_r, cur_wr_r, cur_hi_r, cur_lo_r} <= 5'h00;
         cur_addr_r <= 24'h000000;
      end else if (ce) begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         row_open_r <= row_open_nxt;
         open_bank_r <= open_bank_nxt;
         if (take_c) begin
            cur_bank_r <= acc_bank[0];
            cur_dram_r <= acc_bank[1];
            cur_wr_r <= acc_write;
            cur_hi_r <= acc_hi;
            cur_lo_r <= acc_lo;
            cur_addr_r <= acc_addr;
            open_row_r <= emw_row(acc_addr, d_shift);
         end
      end
   end

   // Output pins, one register stage behind the state
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         rdata_r <= 8'h00;
         done_r <= 1'b0;
         cs_n_r <= 2'b11;
         row_n_r <= 2'b11;
         {rd_n_r, spa_r, spb_r} <= 3'b111;
         spc_r <= 1'b0;
         sra_r <= 1'b0;
         {dpa_r, dpb_r, dpc_r} <= 3'b111;
         maddr_r <= 24'h000000;
      end else if (ce) begin
         rdata_r <= reg_rd ? rd_sel : 8'h00;
         done_r <= done_c;
         cs_n_r <= ~({2{st}} & bank_one);
         rd_n_r <= !(st && !cur_wr_r);
         spa_r <= ssch ? !swr : !(swr && cur_lo_r);
         spb_r <= ssch ? !(st && cur_hi_r) : !(swr && cur_hi_r);
         spc_r <= ssch ? !(st && cur_lo_r) : cur_addr_r[0];
         dpa_r <= dsch ? !(dwr && lane_lo) : !dwr;
         dpb_r <= dsch ? !(dwr && lane_hi) : !(col_act && lane_hi);
         dpc_r <= dsch ? !col_act : !(col_act && lane_lo);
         row_n_r <= ~row_act;
         // Self refresh hold flag, in step with the row pins
         sra_r <= state_r == EMW_SR_HOLD;
         maddr_r <= state_r == EMW_DR_ROW ?
                    emw_row(cur_addr_r, dctl_r[cb][EMW_F_SHIFT +: 2]) :
                    cur_addr_r;
      end
   end

   assign reg_rdata = rdata_r;
   assign acc_done = done_r;
   assign sram_cs_n = cs_n_r;
   assign sram_rd_n = rd_n_r;
   assign sram_we_or_wl_n = spa_r;
   assign sram_hb_or_wh_n = spb_r;
   assign sram_lb_or_a0 = spc_r;
   assign row_strobe_n = row_n_r;
   assign dram_wl_or_we_n = dpa_r;
   assign dram_wh_or_colh_n = dpb_r;
   assign dram_col_or_coll_n = dpc_r;
   assign mux_addr = maddr_r;
   assign self_refresh_active = sra_r;

   // Checks; a frozen cycle disables the attempt
   default clocking cb_chk @(posedge ref_clk); endclocking
   default disable iff (!nrst || !ce);

   AST_STATIC_WAIT: assert property (
      take_c && sreq |=> state_r == EMW_ST_ACC && cnt_r == $past(sw_cyc))
      else $error("static wait count not loaded");
   AST_STATIC_END: assert property (
      st && cnt_r == 4'h0 |=> acc_done && state_r == EMW_IDLE)
      else $error("static access did not end with done");
   AST_RESET_WAIT: assert property (
      $past(!nrst) |-> swait_r == EMW_RST_SWAIT && xtim_r == EMW_RST_XTIM)
      else $error("wait or exit timing reset value wrong");
   AST_ROW_DELAY: assert property (
      $rose(state_r == EMW_DR_ROW) && dtim_r[cb][EMW_F_R2C]
      |-> state_r == EMW_DR_ROW [*2] ##1 state_r == EMW_DR_COL)
      else $error("row-to-column delay not two cycles");
   AST_RANDOM_PRE: assert property (
      col_acc && cnt_r == 4'h0 && !dctl_r[cb][EMW_F_PAGE]
      |=> state_r == EMW_DR_PRE ##1 !row_open_r)
      else $error("random mode did not precharge");
   AST_REF_LOAD: assert property (
      wr_rctl && !arf_on && arf_wdata != 2'b00 |=> rcnt_r == $past(rint_r))
      else $error("refresh counter not loaded on enable");
   AST_REF_FIRST: assert property (
      state_r == EMW_IDLE && ref_pend_r && arf_on && !row_open_r
      |=> state_r == EMW_RF_COL ##1 state_r == EMW_RF_ROW)
      else $error("refresh did not take priority");
   AST_REF_RELOAD: assert property (
      ref_done_c && !wr_rcnt |=> rcnt_r == $past(rint_r) && !ref_pend_r)
      else $error("refresh counter not reloaded");
   AST_SELF_STROBES: assert property (
      state_r == EMW_SR_COL |=> !dpc_r && row_n_r == 2'b11 ##1
      row_n_r == 2'b00)
      else $error("self refresh strobe order wrong");
   AST_SELF_EXIT: assert property (
      state_r == EMW_SR_HOLD && dreq && !wr_rctl |=> !self_r &&
      state_r == EMW_SR_EXIT && cnt_r == $past(xhold_cyc))
      else $error("access did not leave self refresh");
endmodule : emw_ctrl

/* File: tb/emw_mem_model.sv */
/* Chip-side watcher: strobe widths and static pin levels at the memories.
   Assumes the strobes change just after ref_clk edges. */
`timescale 1ns/100ps
module emw_mem_model (
   // Clock
   input wire logic ref_clk,
   // Memory pins
   input wire logic [1:0] sram_cs_n,
   input wire logic [1:0] row_strobe_n,
   input wire logic sram_rd_n,
   input wire logic sram_we_or_wl_n,
   input wire logic sram_hb_or_wh_n,
   input wire logic sram_lb_or_a0,
   // Measured widths, last pin levels under select
   output logic [7:0] cs_len = 8'h00,
   output logic [7:0] ras_cnt = 8'h00,
   output logic [3:0] pins_seen = 4'hf
);
   logic [7:0] run_r = 8'h00; // Select low run
   // select width, pin levels, rows seen
   always @(posedge ref_clk) begin
      run_r <= &sram_cs_n ? 8'h00 : run_r + 8'h01;
      if (&sram_cs_n && run_r != 8'h00) cs_len <= run_r;
      if (!(&sram_cs_n)) pins_seen <= {sram_rd_n, sram_we_or_wl_n,
         sram_hb_or_wh_n, sram_lb_or_a0};
      if (!row_strobe_n[0]) ras_cnt <= ras_cnt + 8'h01;
   end
endmodule : emw_mem_model

/* File: tb/tb.sv */
/* Self-checking bench for emw_ctrl with a chip-side watcher.
   Assumes one 100 MHz clock and a synchronous low reset. */
`timescale 1ns/100ps
module tb;
   import emw_pkg::*;
   logic ref_clk = 0, nrst = 0, ce = 1, reg_wr = 0, reg_rd = 0, acc_done;
   logic acc_req = 0, acc_write = 0, acc_hi = 1, acc_lo = 1;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, time_base_tap = 8'h00;
   logic [7:0] cs_len, ras_cnt, snap, d, lfsr_r = 8'h02;
   logic [1:0] acc_bank = 2'h0, sram_cs_n, row_strobe_n;
   logic [23:0] acc_addr = 24'h0, mux_addr;
   logic sram_rd_n, sram_we_or_wl_n, sram_hb_or_wh_n, sram_lb_or_a0;
   logic dram_wl_or_we_n, dram_wh_or_colh_n, dram_col_or_coll_n, self_act;
   logic [15:0] ri;
   logic [2:0] w;
   logic [3:0] pins_seen;
   int bad_count = 0, cmp_count = 0;
   always #5 ref_clk = ~ref_clk;
   // Divider taps, bit k divides by 2^(k+1)
   always @(posedge ref_clk) time_base_tap <= time_base_tap + 8'h01;
   emw_ctrl emw_ctrl_i (.ref_clk, .nrst, .ce, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .acc_req, .acc_bank, .acc_write,
      .acc_hi, .acc_lo, .acc_addr, .acc_done, .time_base_tap, .sram_cs_n,
      .sram_rd_n, .sram_we_or_wl_n, .sram_hb_or_wh_n, .sram_lb_or_a0,
      .row_strobe_n, .dram_wl_or_we_n, .dram_wh_or_colh_n,
      .dram_col_or_coll_n, .mux_addr, .self_refresh_active(self_act));
   emw_mem_model emw_mem_model_i (.ref_clk, .sram_cs_n, .row_strobe_n,
      .sram_rd_n, .sram_we_or_wl_n, .sram_hb_or_wh_n, .sram_lb_or_a0,
      .cs_len, .ras_cnt, .pins_seen);
   function automatic logic [7:0] nxt(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction : nxt
   // Static pins {rd, a, b, c}, both lanes; address bit 0 equals write
   function automatic logic [3:0] exp_pins(input logic s, input logic w);
      return s ? {w, !w, 2'b00} : {w, !w, !w, w};
   endfunction : exp_pins
   // Reset value over writable mask
   function automatic logic [15:0] reg_info(input logic [3:0] a);
      case (a)
         EMW_A_SWAIT: return {EMW_RST_SWAIT, EMW_M_SWAIT};
         EMW_A_BSCH: return {EMW_RST_BSCH, EMW_M_BSCH};
         EMW_A_DCTL2, EMW_A_DCTL3: return {EMW_RST_DCTL, EMW_M_DCTL};
         EMW_A_DTIM2, EMW_A_DTIM3: return {EMW_RST_DTIM, EMW_M_DTIM};
         EMW_A_DCW2, EMW_A_DCW3: return {EMW_RST_DCW, EMW_M_DCW};
         EMW_A_RCNT, EMW_A_RINT: return 16'hffff;
         EMW_A_XTIM: return {EMW_RST_XTIM, EMW_M_XTIM};
         EMW_A_RCTL: return {EMW_RST_RCTL, EMW_M_RCTL};
         default: return 16'h0000;
      endcase
   endfunction : reg_info
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr
   // Data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask : rd
   // Request held until the done pulse is seen
   task automatic acc(input logic [1:0] b);
      @(posedge ref_clk);
      acc_req <= 1'b1;
      acc_bank <= b;
      acc_addr <= {lfsr_r, ~lfsr_r, lfsr_r};
      acc_write <= lfsr_r[0];
      for (int i = 0; i < 300; i++) begin
         @(posedge ref_clk);
         #1 if (acc_done === 1'b1) break;
      end
      acc_req <= 1'b0;
      chk({7'h00, acc_done}, 8'h01);
   endtask : acc
   task automatic print_verdict;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : print_verdict
   initial begin
      #100000 bad_count++;
      print_verdict;
   end
   initial begin
      repeat (6) @(posedge ref_clk);
      nrst <= 1'b1;
      for (int a = 0; a < 16; a++) begin
         ri = reg_info(4'(a));
         rd(4'(a), ri[15:8]);
      end
      for (int a = 3; a < 14; a++) begin
         ri = reg_info(4'(a));
         lfsr_r = nxt(lfsr_r);
         d = lfsr_r & ri[7:0];
         if (a == 4) d = {6'h00, {2{d[0]}}};
         wr(4'(a), d);
         rd(4'(a), d);
      end
      for (int i = 0; i < 4; i++) begin
         lfsr_r = nxt(lfsr_r);
         w = (i == 0) ? 3'h0 : (i == 1) ? 3'h7 : lfsr_r[2:0];
         wr(EMW_A_SWAIT, {1'b0, w, 1'b0, w});
         wr(EMW_A_BSCH, {6'h00, {2{i[1]}}});
         acc({1'b0, i[0]});
         repeat (3) @(posedge ref_clk);
         #1 chk(cs_len, 8'(w) + 8'h01);
         chk({4'h0, pins_seen}, {4'h0, exp_pins(i[1], lfsr_r[0])});
      end
      acc(2'h2);
      wr(EMW_A_RCTL, 8'h08);
      repeat (6) @(posedge ref_clk);
      #1 chk({7'h00, self_act}, 8'h01);
      wr(EMW_A_RCTL, 8'h00);
      repeat (2) @(posedge ref_clk);
      #1 chk({7'h00, self_act}, 8'h00);
      wr(EMW_A_RCTL, 8'h08);
      repeat (6) @(posedge ref_clk);
      acc(2'h3);
      rd(EMW_A_RCTL, 8'h00);
      snap = ras_cnt;
      wr(EMW_A_RINT, 8'h03);
      wr(EMW_A_RCTL, 8'h11);
      repeat (100) @(posedge ref_clk);
      #1 chk({7'h00, ras_cnt != snap}, 8'h01);
      print_verdict;
   end
endmodule : tb
